// [design/servo_gain_consts.svh]
// Register map, reset values, ranges and timing constants of the gain switching block.
`ifndef SERVO_GAIN_CONSTS_SVH
`define SERVO_GAIN_CONSTS_SVH
`define CLK_PERIOD_PS 4000
`define CYC_PER_MS (1000000000 / `CLK_PERIOD_PS)
`define BLEND_STEPS 256
`define R_LPF_SEL 0
`define R_LPF_BW 1
`define R_VIB_FREQ 2
`define R_RES_FREQ 3
`define R_SLIGHT 4
`define R_GC_SEL 5
`define R_GC_THR 6
`define R_GC_TC 7
`define R_ALT_INERTIA 8
`define R_ALT_POS 9
`define R_ALT_SPEED 10
`define R_ALT_INT 11
`define R_BASE_POS 12
`define R_BASE_INERTIA 13
`define R_BASE_SPEED 14
`define R_BASE_INT 15
`define R_AT_MODE 16
`define R_VS_MODE 17
`define R_RESERVED 18
`define NUM_CFG 19
`define R_STATUS 19
`define R_EFF_POS 20
`define R_EFF_SPEED 21
`define R_EFF_INERTIA 22
`define R_EFF_INT 23
`define NUM_REGS 24
`define IDX_W 5
`define LPF_MODE_MSB 7
`define LPF_MODE_LSB 4
`define LPF_AUTO 4'h0
`define VS_MODE_MSB 3
`define VS_AUTO 4'h1
`define VS_MANUAL 4'h2
`define AT_MODE_MSB 3
`define AT_MANUAL 4'h3
`define GC_SRC_MSB 3
`define GC_POL_BIT 4
`define ST_COND_BIT 0
`define ST_TARGET_BIT 1
`define ST_W_LSB 8
`define RST_LPF_BW 16'h0c45
`define RST_FREQ 16'h03e8
`define RST_THR 16'h000a
`define RST_TC 16'h0001
`define RST_INERTIA 16'h0046
`define RST_POS 16'h0025
`define RST_SPEED 16'h0337
`define RST_INT 16'h0151
`define RST_AT_MODE 16'h0001
`define LPF_MIN 16'h0064
`define LPF_MAX 16'h4650
`define FREQ_MIN 16'h0001
`define FREQ_MAX 16'h03e8
`define THR_MAX 16'h270f
`define TC_MAX 16'h0064
`define INERTIA_MAX 16'h0bb8
`define ALT_POS_MAX 16'h07d0
`define BASE_POS_MAX 16'h03e8
`define GAIN_MIN 16'h0001
`define SPEED_MIN 16'h0014
`define SPEED_MAX 16'hc350
`define ALT_INT_MAX 16'hc350
`define BASE_INT_MAX 16'h2710
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// [design/servo_gain_pkg.sv]
// Types shared by the gain switching block and its bench.
package servo_gain_pkg;
	typedef logic [15:0] word_t;
	typedef struct packed {
		word_t inertia;
		word_t position;
		word_t speed;
		word_t integral;
	} gain_set_t;
	typedef enum logic [2:0] {
		GC_OFF = 3'h0,
		GC_INPUT = 3'h1,
		GC_CMD_FREQ = 3'h2,
		GC_DROOP = 3'h3,
		GC_SPEED = 3'h4
	} gc_src_t;
endpackage

// [design/servo_gain_switching.sv]
// Gain scheduling and filter setting logic with an AXI4-Lite register file.
`timescale 1ns/100ps
`include "servo_gain_consts.svh"

// Notes on behaviour
// - With the low-pass selection in automatic, the tuned bandwidth overwrites the stored one.
// - With the low-pass selection in manual, the written bandwidth, 100 to 18000, default 3141, is used.
// - Vibration frequency is tuned when the suppression mode is 1 and user set when 2, default 100.0 Hz.
// - Resonance frequency follows the same rule, range 0.1 to 100.0 Hz, default 100.0 Hz.
// - Slight vibration suppression applies only in tuning mode 3, is ignored otherwise, default zero.
// - Gain change source: 0 off, 1 input bit, 2 command frequency, 3 droop pulses, 4 motor speed.
// - Polarity 0 switches above the threshold or on the bit set, 1 below or on the bit clear.
// - While the condition holds in tuning mode 3, the alternate inertia, position, speed and integral gains apply.
// - The threshold takes 0 to 9999, default 10, in the unit of the chosen source.
// - Moving between gain sets follows a time constant of 0 to 100 ms, default 1 ms.
// - Alternate inertia ratio takes 0 to 300.0, default 7.0, only with tuning mode 3.
// - Alternate position gain takes 1 to 2000, default 37, only with tuning mode 3.
// - Alternate speed gain defaults to 823 with an upper limit of 20000 or 50000, mode 3 only.
// - Alternate integral time takes 0.1 to 5000.0 ms, default 33.7 ms, mode 3 only.
// - With gain changing inactive the base position gain, default 37, drives the loop.
module servo_gain_switching #(
	parameter int CYC_PER_MS = `CYC_PER_MS,
	parameter logic [15:0] SPEED_GAIN_MAX = `SPEED_MAX
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic gain_change_in,
	input wire logic ctrl_tick,
	input wire logic [15:0] command_freq,
	input wire logic signed [31:0] droop_pulses,
	input wire logic signed [15:0] motor_speed,
	input wire logic [15:0] auto_lowpass_bw,
	input wire logic [15:0] auto_vib_freq,
	input wire logic [15:0] auto_res_freq,
	output logic [15:0] lowpass_bandwidth,
	output logic [15:0] vib_supp_vibration_freq,
	output logic [15:0] vib_supp_resonance_freq,
	output logic [15:0] slight_vib_supp_select,
	output servo_gain_pkg::gain_set_t active_gains,
	output logic gain_change_active
);
	localparam int STEP_CYC = CYC_PER_MS / `BLEND_STEPS;

	function automatic logic [15:0] clip(input logic [15:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		clip = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	function automatic logic [15:0] limit(input int idx, input logic [15:0] v);
		case (idx)
			`R_LPF_BW: limit = clip(v, `LPF_MIN, `LPF_MAX);
			`R_VIB_FREQ, `R_RES_FREQ: limit = clip(v, `FREQ_MIN, `FREQ_MAX);
			`R_GC_THR: limit = clip(v, 16'h0000, `THR_MAX);
			`R_GC_TC: limit = clip(v, 16'h0000, `TC_MAX);
			`R_ALT_INERTIA, `R_BASE_INERTIA: limit = clip(v, 16'h0000, `INERTIA_MAX);
			`R_ALT_POS: limit = clip(v, `GAIN_MIN, `ALT_POS_MAX);
			`R_ALT_SPEED: limit = clip(v, `SPEED_MIN, SPEED_GAIN_MAX);
			`R_ALT_INT: limit = clip(v, `GAIN_MIN, `ALT_INT_MAX);
			`R_BASE_POS: limit = clip(v, `GAIN_MIN, `BASE_POS_MAX);
			`R_BASE_SPEED: limit = clip(v, `SPEED_MIN, `SPEED_MAX);
			`R_BASE_INT: limit = clip(v, `GAIN_MIN, `BASE_INT_MAX);
			default: limit = v;
		endcase
	endfunction

	function automatic logic [15:0] reset_value(input int idx);
		case (idx)
			`R_LPF_BW: reset_value = `RST_LPF_BW;
			`R_VIB_FREQ, `R_RES_FREQ: reset_value = `RST_FREQ;
			`R_GC_THR: reset_value = `RST_THR;
			`R_GC_TC: reset_value = `RST_TC;
			`R_ALT_INERTIA, `R_BASE_INERTIA: reset_value = `RST_INERTIA;
			`R_ALT_POS, `R_BASE_POS: reset_value = `RST_POS;
			`R_ALT_SPEED, `R_BASE_SPEED: reset_value = `RST_SPEED;
			`R_ALT_INT, `R_BASE_INT: reset_value = `RST_INT;
			`R_AT_MODE: reset_value = `RST_AT_MODE;
			default: reset_value = 16'h0000;
		endcase
	endfunction

	function automatic logic [15:0] blend(input logic [15:0] base, input logic [15:0] alt,
		input logic [8:0] w);
		logic signed [17:0] diff;
		logic signed [27:0] prod;
		logic signed [27:0] sum;
		diff = $signed({2'b00, alt}) - $signed({2'b00, base});
		prod = diff * $signed({1'b0, w});
		sum = $signed({12'h000, base}) + (prod >>> 8);
		blend = sum[15:0];
	endfunction

	logic [15:0] cfg [0:`NUM_CFG-1];
	logic [15:0] next_cfg [0:`NUM_CFG-1];
	logic aw_hold, next_aw_hold, w_hold, next_w_hold;
	logic [`IDX_W-1:0] aw_idx, next_aw_idx;
	logic aw_bad, next_aw_bad;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata;
	logic sync1, sync2, cond, target;
	logic next_cond, next_target;
	logic [8:0] weight, next_weight;
	logic [23:0] step_cnt, next_step_cnt;
	logic [15:0] next_lpf, next_vib, next_res, next_slight;
	servo_gain_pkg::gain_set_t next_gains;
	logic manual_mode;

	// Register bus and configuration storage.
	function automatic logic [31:0] read_word(input logic [`IDX_W-1:0] idx);
		case (idx)
			`R_STATUS: read_word = {15'h0000, weight, 6'h00, target, cond};
			`R_EFF_POS: read_word = {16'h0000, active_gains.position};
			`R_EFF_SPEED: read_word = {16'h0000, active_gains.speed};
			`R_EFF_INERTIA: read_word = {16'h0000, active_gains.inertia};
			`R_EFF_INT: read_word = {16'h0000, active_gains.integral};
			default: read_word = {16'h0000, cfg[idx]};
		endcase
	endfunction

	always_comb begin
		logic [15:0] merged;
		logic do_write;
		merged = 16'h0000;
		do_write = aw_hold && w_hold && !s_axi_bvalid;
		next_cfg = cfg;
		next_aw_hold = aw_hold;
		next_aw_idx = aw_idx;
		next_aw_bad = aw_bad;
		next_w_hold = w_hold;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = s_axi_bvalid && !s_axi_bready;
		next_bresp = s_axi_bresp;
		next_awready = s_axi_awready ? !s_axi_awvalid : (s_axi_bvalid && s_axi_bready);
		next_wready = s_axi_wready ? !s_axi_wvalid : (s_axi_bvalid && s_axi_bready);
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_hold = 1'b1;
			next_aw_idx = s_axi_awaddr[`IDX_W+1:2];
			next_aw_bad = (s_axi_awaddr[31:2] >= 30'(`NUM_CFG)) || (s_axi_awaddr[1:0] != 2'h0);
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_hold = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (do_write) begin
			next_aw_hold = 1'b0;
			next_w_hold = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = aw_bad ? `RESP_SLVERR : `RESP_OKAY;
			if (!aw_bad) begin
				merged = cfg[aw_idx];
				if (w_strb[0]) merged[7:0] = w_data[7:0];
				if (w_strb[1]) merged[15:8] = w_data[15:8];
				next_cfg[aw_idx] = limit(int'(aw_idx), merged);
			end
		end
		if (cfg[`R_LPF_SEL][`LPF_MODE_MSB:`LPF_MODE_LSB] == `LPF_AUTO) begin
			next_cfg[`R_LPF_BW] = limit(`R_LPF_BW, auto_lowpass_bw);
		end
		if (cfg[`R_VS_MODE][`VS_MODE_MSB:0] == `VS_AUTO) begin
			next_cfg[`R_VIB_FREQ] = limit(`R_VIB_FREQ, auto_vib_freq);
			next_cfg[`R_RES_FREQ] = limit(`R_RES_FREQ, auto_res_freq);
		end
		next_arready = s_axi_arready ? !s_axi_arvalid : (s_axi_rvalid && s_axi_rready);
		next_rvalid = s_axi_rvalid && !s_axi_rready;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			if ((s_axi_araddr[31:2] >= 30'(`NUM_REGS)) || (s_axi_araddr[1:0] != 2'h0)) begin
				next_rdata = 32'h0000_0000;
				next_rresp = `RESP_SLVERR;
			end else begin
				next_rdata = read_word(s_axi_araddr[`IDX_W+1:2]);
				next_rresp = `RESP_OKAY;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < `NUM_CFG; i++) begin
				cfg[i] <= reset_value(i);
			end
			aw_hold <= 1'b0;
			aw_idx <= '0;
			aw_bad <= 1'b0;
			w_hold <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RESP_OKAY;
		end else begin
			cfg <= next_cfg;
			aw_hold <= next_aw_hold;
			aw_idx <= next_aw_idx;
			aw_bad <= next_aw_bad;
			w_hold <= next_w_hold;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end

	// Gain change condition, blend weight and loop outputs.
	assign manual_mode = cfg[`R_AT_MODE][`AT_MODE_MSB:0] == `AT_MANUAL;

	always_comb begin
		servo_gain_pkg::gc_src_t src;
		logic pol;
		logic [31:0] mag;
		logic hit;
		logic [23:0] step_len;
		src = servo_gain_pkg::GC_OFF;
		if (cfg[`R_GC_SEL][`GC_SRC_MSB:0] <= 4'(servo_gain_pkg::GC_SPEED)) begin
			src = servo_gain_pkg::gc_src_t'(cfg[`R_GC_SEL][`GC_SRC_MSB-1:0]);
		end
		pol = cfg[`R_GC_SEL][`GC_POL_BIT];
		mag = 32'h0000_0000;
		hit = 1'b0;
		step_len = 24'(cfg[`R_GC_TC] * STEP_CYC);
		case (src)
			servo_gain_pkg::GC_INPUT: hit = pol ? !sync2 : sync2;
			servo_gain_pkg::GC_CMD_FREQ: mag = {16'h0000, command_freq};
			servo_gain_pkg::GC_DROOP: mag = droop_pulses[31] ? 32'(-droop_pulses) : droop_pulses;
			servo_gain_pkg::GC_SPEED: mag = {16'h0000, motor_speed[15] ? 16'(-motor_speed) : motor_speed};
			default: hit = 1'b0;
		endcase
		if (src > servo_gain_pkg::GC_INPUT) begin
			hit = pol ? (mag < {16'h0000, cfg[`R_GC_THR]}) : (mag > {16'h0000, cfg[`R_GC_THR]});
		end
		next_cond = ctrl_tick ? hit : cond;
		next_target = cond && manual_mode;
		next_step_cnt = step_cnt;
		next_weight = weight;
		if (cfg[`R_GC_TC] == 16'h0000) begin
			next_weight = target ? 9'(`BLEND_STEPS) : 9'h000;
			next_step_cnt = 24'h000000;
		end else if ((target && weight != 9'(`BLEND_STEPS)) || (!target && weight != 9'h000)) begin
			next_step_cnt = step_cnt + 24'h000001;
			if (next_step_cnt >= step_len) begin
				next_step_cnt = 24'h000000;
				next_weight = target ? weight + 9'h001 : weight - 9'h001;
			end
		end else begin
			next_step_cnt = 24'h000000;
		end
		next_gains.inertia = blend(cfg[`R_BASE_INERTIA], cfg[`R_ALT_INERTIA], weight);
		next_gains.position = blend(cfg[`R_BASE_POS], cfg[`R_ALT_POS], weight);
		next_gains.speed = blend(cfg[`R_BASE_SPEED], cfg[`R_ALT_SPEED], weight);
		next_gains.integral = blend(cfg[`R_BASE_INT], cfg[`R_ALT_INT], weight);
		next_lpf = cfg[`R_LPF_BW];
		next_vib = cfg[`R_VIB_FREQ];
		next_res = cfg[`R_RES_FREQ];
		next_slight = manual_mode ? cfg[`R_SLIGHT] : 16'h0000;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			cond <= 1'b0;
			target <= 1'b0;
			weight <= 9'h000;
			step_cnt <= 24'h000000;
			gain_change_active <= 1'b0;
			active_gains <= {`RST_INERTIA, `RST_POS, `RST_SPEED, `RST_INT};
			lowpass_bandwidth <= `RST_LPF_BW;
			vib_supp_vibration_freq <= `RST_FREQ;
			vib_supp_resonance_freq <= `RST_FREQ;
			slight_vib_supp_select <= 16'h0000;
		end else begin
			sync1 <= gain_change_in;
			sync2 <= sync1;
			cond <= next_cond;
			target <= next_target;
			weight <= next_weight;
			step_cnt <= next_step_cnt;
			gain_change_active <= next_target;
			active_gains <= next_gains;
			lowpass_bandwidth <= next_lpf;
			vib_supp_vibration_freq <= next_vib;
			vib_supp_resonance_freq <= next_res;
			slight_vib_supp_select <= next_slight;
		end
	end
endmodule // servo_gain_switching

// [dv/servo_gain_monitor.sv]
// Concurrent checks on the ports of the gain switching block.
`timescale 1ns/100ps
module servo_gain_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ctrl_tick,
	input wire logic [15:0] lowpass_bandwidth,
	input wire logic [15:0] vib_supp_vibration_freq,
	input wire logic [15:0] vib_supp_resonance_freq,
	input wire servo_gain_pkg::gain_set_t active_gains,
	input wire logic gain_change_active
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
	property p_wr_lat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
	endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_bw_range; lowpass_bandwidth >= 16'h0064 && lowpass_bandwidth <= 16'h4650; endproperty
	a_bw_range: assert property (p_bw_range) else $error("bandwidth out of range");
	property p_freq_range;
		vib_supp_vibration_freq inside {[16'h0001:16'h03e8]} && vib_supp_resonance_freq != 16'h0000;
	endproperty
	a_freq_range: assert property (p_freq_range) else $error("frequency out of range");
	property p_pos_range; active_gains.position inside {[16'h0001:16'h07d0]}; endproperty
	a_pos_range: assert property (p_pos_range) else $error("position gain out of range");
	property p_inert_range; active_gains.inertia <= 16'h0bb8 && active_gains.speed >= 16'h0014; endproperty
	a_inert_range: assert property (p_inert_range) else $error("gain out of range");
	property p_int_range; active_gains.integral inside {[16'h0001:16'hc350]}; endproperty
	a_int_range: assert property (p_int_range) else $error("integral out of range");
	property p_tick;
		$changed(gain_change_active) |-> $past(ctrl_tick) || $past(ctrl_tick, 2) || $past(ctrl_tick, 3);
	endproperty
	a_tick: assert property (p_tick) else $error("gain change off the control cycle");
endmodule // servo_gain_monitor
bind servo_gain_switching servo_gain_monitor mon_u (.*);

// [dv/servo_plant_model.sv]
// Behavioural servo motor and encoder giving control ticks and measured quantities.
`timescale 1ns/100ps
module servo_plant_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [15:0] level,
	output logic ctrl_tick,
	output logic [15:0] command_freq,
	output logic signed [31:0] droop_pulses,
	output logic signed [15:0] motor_speed
);
	logic [2:0] cnt;
	always_ff @(posedge aclk) begin
		cnt <= aresetn ? cnt + 3'h1 : 3'h0;
		ctrl_tick <= aresetn && (cnt == 3'h7);
		command_freq <= level;
		droop_pulses <= -$signed({16'h0000, level});
		motor_speed <= -$signed(level);
	end
endmodule // servo_plant_model

// [dv/tb.sv]
// Register level testbench of the gain switching block.
`timescale 1ns/100ps
`include "servo_gain_consts.svh"
module tb;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, gc_in, tick, act, on_exp;
	logic [31:0] awaddr, wdata, araddr, rdata, d;
	logic [1:0] bresp, rresp, r;
	logic [15:0] level, abw, avf, arf, cf, bw, vf, rf, sl;
	logic signed [31:0] droop;
	logic signed [15:0] spd;
	servo_gain_pkg::gain_set_t g;
	int error_cnt = 0, n_tests = 0, i, s, p;
	int idx[11] = '{6, 7, 8, 9, 10, 11, 12, 2, 3, 4, 18};
	logic [15:0] dv[11] = '{16'h000a, 16'h0001, 16'h0046, 16'h0025, 16'h0337, 16'h0151,
		16'h0025, 16'h03e8, 16'h03e8, 16'h0000, 16'h0000};
	servo_gain_switching #(.CYC_PER_MS(2560)) dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.gain_change_in(gc_in), .ctrl_tick(tick), .command_freq(cf), .droop_pulses(droop),
		.motor_speed(spd), .auto_lowpass_bw(abw), .auto_vib_freq(avf), .auto_res_freq(arf),
		.lowpass_bandwidth(bw), .vib_supp_vibration_freq(vf), .vib_supp_resonance_freq(rf),
		.slight_vib_supp_select(sl), .active_gains(g), .gain_change_active(act));
	servo_plant_model plant_u (.aclk(aclk), .aresetn(aresetn), .level(level),
		.ctrl_tick(tick), .command_freq(cf), .droop_pulses(droop), .motor_speed(spd));
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic timeout(input int n);
		if (n >= 50) begin
			check(32'h0, 32'h1);
			give_verdict;
		end
	endtask
	task automatic wr(input int a, input logic [31:0] v, input logic [1:0] er);
		int n;
		logic pa, pw;
		@(posedge aclk);
		awaddr <= 32'(a * 4);
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		pa = 1'b1;
		pw = 1'b1;
		n = 0;
		while ((pa || pw) && n < 50) begin
			@(posedge aclk);
			if (pa && awready) begin
				pa = 1'b0;
				awvalid <= 1'b0;
			end
			if (pw && wready) begin
				pw = 1'b0;
				wvalid <= 1'b0;
			end
			n++;
		end
		timeout(n);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (!bvalid && n < 50);
		timeout(n);
		check(bresp, er);
		bready <= 1'b0;
	endtask
	task automatic rd(input int a, output logic [31:0] v, output logic [1:0] rs);
		int n;
		@(posedge aclk);
		araddr <= 32'(a * 4);
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (!arready && n < 50);
		arvalid <= 1'b0;
		while (!rvalid && n < 50) begin
			@(posedge aclk);
			n++;
		end
		timeout(n);
		v = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask
	initial begin
		repeat (100000) @(posedge aclk);
		check(32'h0, 32'h1);
		give_verdict;
	end
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, gc_in} = 7'h00;
		{awaddr, wdata, araddr} = 96'h0;
		level = 16'h003c;
		abw = 16'h01f4;
		avf = 16'h00c8;
		arf = 16'h012c;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		for (i = 0; i < 11; i++) begin
			rd(idx[i], d, r);
			check(d, {16'h0000, dv[i]});
			check(r, `RESP_OKAY);
		end
		rd(`R_RESERVED, d, r);
		check(d, 32'h0000_0000);
		check(bw, 16'h01f4);
		wr(`R_LPF_SEL, 32'h10, `RESP_OKAY);
		wr(`R_LPF_BW, 32'h4e20, `RESP_OKAY);
		rd(`R_LPF_BW, d, r);
		check(d, 32'h4650);
		repeat (4) @(posedge aclk);
		check(bw, 16'h4650);
		wr(`R_VS_MODE, 32'h1, `RESP_OKAY);
		repeat (4) @(posedge aclk);
		check({vf, rf}, {avf, arf});
		wr(`R_SLIGHT, 32'h11, `RESP_OKAY);
		repeat (4) @(posedge aclk);
		check(sl, 16'h0000);
		wr(`R_AT_MODE, 32'h3, `RESP_OKAY);
		repeat (4) @(posedge aclk);
		check(sl, 16'h0011);
		wr(`R_ALT_POS, 32'h64, `RESP_OKAY);
		wr(`R_ALT_INERTIA, 32'h64, `RESP_OKAY);
		wr(`R_ALT_SPEED, 32'h3e8, `RESP_OKAY);
		wr(`R_GC_THR, 32'h32, `RESP_OKAY);
		wr(`R_GC_TC, 32'h0, `RESP_OKAY);
		gc_in <= 1'b1;
		for (i = 0; i < 10; i++) begin
			s = i % 5;
			p = i / 5;
			on_exp = s != 0 && p == 0;
			wr(`R_GC_SEL, 32'(p * 16 + s), `RESP_OKAY);
			repeat (40) @(posedge aclk);
			check(act, on_exp);
			check(g.position, on_exp ? 16'h0064 : 16'h0025);
			check({g.inertia, g.speed}, on_exp ? 32'h0064_03e8 : 32'h0046_0337);
			rd(`R_STATUS, d, r);
			check(d, on_exp ? 32'h0001_0003 : 32'h0000_0000);
			rd(`R_EFF_POS, d, r);
			check(d, on_exp ? 32'h0000_0064 : 32'h0000_0025);
		end
		wr(`R_GC_SEL, 32'h15, `RESP_OKAY);
		repeat (40) @(posedge aclk);
		check(act, 1'b0);
		level <= 16'h0028;
		wr(`R_GC_SEL, 32'h12, `RESP_OKAY);
		repeat (40) @(posedge aclk);
		check(act, 1'b1);
		level <= 16'h0032;
		wr(`R_GC_SEL, 32'h4, `RESP_OKAY);
		repeat (40) @(posedge aclk);
		check(act, 1'b0);
		wr(`R_GC_TC, 32'h1, `RESP_OKAY);
		level <= 16'h003c;
		repeat (300) @(posedge aclk);
		check(g.position > 16'h0025 && g.position < 16'h0064, 1'b1);
		wr(19, 32'h1, `RESP_SLVERR);
		rd(24, d, r);
		check(r, `RESP_SLVERR);
		check(d, 32'h0000_0000);
		give_verdict;
	end
endmodule // tb
